// [dstc_channel_ctrl.sv]
// Single transfer DMA controller: several channels share one cycle-steal bus master.
// Assumes the memory bus acknowledges each request with a one-cycle busAck pulse.
//
// Functional notes
// - There are four independent channels, each moving byte, halfword or word units.
// - Each accepted trigger makes the channel read one unit at its source and write it at its destination.
// - Single transfer mode moves exactly one unit per trigger, never a burst.
// - Each channel selects its trigger, software pulse or external pin falling edge.
// - With the external trigger chosen, a falling edge on the pin starts a source to destination transfer.
// - After each byte transfer the counter drops by one and an incrementing source advances by one.
// - With halfword size an incrementing source advances by two after each transfer.
// - While the transfer counter is zero, triggers are ignored and nothing is moved.
`timescale 1ns/1ps

module dstc_channel_ctrl
  import dstc_pkg::*;
#(
  parameter int NUM_CH = DSTC_NUM_CH,
  parameter int BUF_DEPTH = DSTC_BUF_DEPTH
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Channel set-up
  input wire logic [NUM_CH-1:0] cfgLoad,
  input wire dstc_cfg_t [NUM_CH-1:0] cfgData,
  // Triggers
  input wire logic [NUM_CH-1:0] swTrig,
  input wire logic [NUM_CH-1:0] externalTriggerInput,
  // Memory bus master
  output logic busReq,
  output logic busWrite,
  output logic [DSTC_ADDR_W-1:0] busAddr,
  output logic [DSTC_DATA_W-1:0] busWdata,
  output dstc_size_t busSize,
  input wire logic busAck,
  input wire logic [DSTC_DATA_W-1:0] busRdata,
  // Channel status
  output logic [NUM_CH-1:0][DSTC_CNT_W-1:0] transferCounter,
  output logic [NUM_CH-1:0][DSTC_ADDR_W-1:0] sourceAddress,
  output logic [NUM_CH-1:0][DSTC_ADDR_W-1:0] destinationAddress,
  output logic [NUM_CH-1:0] chPending,
  output logic xferDone,
  output logic [DSTC_CH_W-1:0] xferDoneCh
);

  // The channel index field of a beat is two bits and the buffer pointers are one bit.
  if (NUM_CH < 1 || NUM_CH > DSTC_MAX_CH || BUF_DEPTH != 2)
  begin : g_bad_param
    $error("NUM_CH must lie between 1 and 4 and BUF_DEPTH must be 2");
  end

  // Address step for one unit of the given size.
  function automatic logic [DSTC_ADDR_W-1:0] unitStep(input dstc_size_t sz);
    case (sz)
      DSTC_SZ_HALF: unitStep = DSTC_STEP_HALF;
      DSTC_SZ_WORD: unitStep = DSTC_STEP_WORD;
      default: unitStep = DSTC_STEP_BYTE;
    endcase
  endfunction

  // Lowest numbered requesting channel wins the bus.
  function automatic logic [DSTC_CH_W-1:0] firstSet(input logic [NUM_CH-1:0] v);
    firstSet = '0;
    for (int i = NUM_CH - 1; i >= 0; i--)
      if (v[i])
        firstSet = DSTC_CH_W'(i);
  endfunction

  dstc_mode_t channelModeReg [NUM_CH];
  logic [DSTC_CNT_W-1:0] transferCountReg [NUM_CH];
  logic [DSTC_ADDR_W-1:0] sourceAddressReg [NUM_CH];
  logic [DSTC_ADDR_W-1:0] destinationAddressReg [NUM_CH];
  logic [NUM_CH-1:0] pendingReg;
  logic [NUM_CH-1:0] syncAReg;
  logic [NUM_CH-1:0] syncBReg;
  logic [NUM_CH-1:0] prevPinReg;
  dstc_state_t stateReg;
  logic [DSTC_CH_W-1:0] activeChReg;
  logic busReqReg;
  logic busWriteReg;
  logic [DSTC_ADDR_W-1:0] busAddrReg;
  logic [DSTC_DATA_W-1:0] busWdataReg;
  dstc_size_t busSizeReg;
  logic xferDoneReg;
  logic [DSTC_CH_W-1:0] xferDoneChReg;

  // Two-entry buffer between the read and the write of a unit.
  dstc_beat_t bufMem [BUF_DEPTH];
  logic bufWrPtrReg;
  logic bufRdPtrReg;
  logic [1:0] bufCountReg;
  logic bufInValid;
  logic bufInReady;
  logic bufOutValid;
  logic bufOutReady;
  dstc_beat_t bufIn;
  dstc_beat_t bufOut;

  // Engine decode.
  logic [NUM_CH-1:0] eligible;
  logic grantValid;
  logic [DSTC_CH_W-1:0] grantCh;
  logic startRead;
  logic readDone;
  logic startWrite;
  logic writeDone;
  logic [NUM_CH-1:0] pinFall;
  logic [NUM_CH-1:0] trigHit;
  logic [NUM_CH-1:0] trigAccept;
  logic [NUM_CH-1:0] countNonZero;

  // A channel may only be served while it holds a nonzero count.
  assign eligible = pendingReg & countNonZero;
  assign grantValid = |eligible;
  assign grantCh = firstSet(eligible);
  // A read is issued only when the buffer can take its data, so a stall never drops a unit.
  assign startRead = (stateReg == DSTC_ST_IDLE) && grantValid && bufInReady;
  assign readDone = (stateReg == DSTC_ST_READ) && busReqReg && busAck;
  assign startWrite = (stateReg == DSTC_ST_WRITE) && !busReqReg && bufOutValid;
  assign writeDone = (stateReg == DSTC_ST_WRITE) && busReqReg && busAck;

  // Buffer handshakes and entry layout.
  assign bufInValid = readDone;
  assign bufIn = '{busRdata, destinationAddressReg[activeChReg], busSizeReg, activeChReg};
  assign bufOutReady = writeDone;
  assign bufInReady = (bufCountReg != 2'h2);
  assign bufOutValid = (bufCountReg != 2'h0);
  assign bufOut = bufMem[bufRdPtrReg];

  // Buffer storage and pointers.
  always_ff @(posedge clk)
  begin
    if (bufInValid && bufInReady)
      bufMem[bufWrPtrReg] <= bufIn;
    if (rst)
    begin
      bufWrPtrReg <= 1'b0;
      bufRdPtrReg <= 1'b0;
      bufCountReg <= 2'h0;
    end
    else
    begin
      bufWrPtrReg <= bufWrPtrReg ^ (bufInValid && bufInReady);
      bufRdPtrReg <= bufRdPtrReg ^ (bufOutValid && bufOutReady);
      bufCountReg <= 2'(bufCountReg + (bufInValid && bufInReady) - (bufOutValid && bufOutReady));
    end
  end

  // Pin synchroniser; the falling edge is taken between the second and third stage.
  assign pinFall = prevPinReg & ~syncBReg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      syncAReg <= '1;
      syncBReg <= '1;
      prevPinReg <= '1;
    end
    else
    begin
      syncAReg <= externalTriggerInput;
      syncBReg <= syncAReg;
      prevPinReg <= syncBReg;
    end
  end

  // Per-channel registers; a load pulse overrides any update in the same cycle.
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    logic isDone;
    assign countNonZero[c] = (transferCountReg[c] != DSTC_COUNT_ZERO);
    assign trigHit[c] = (channelModeReg[c].trig == DSTC_TRIG_EXT_FALL) ? pinFall[c] : swTrig[c];
    assign trigAccept[c] = trigHit[c] && countNonZero[c];
    assign isDone = writeDone && (bufOut.ch == DSTC_CH_W'(c));

    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        channelModeReg[c] <= DSTC_MODE_RST;
        transferCountReg[c] <= DSTC_COUNT_RST;
        sourceAddressReg[c] <= DSTC_ADDR_RST;
        destinationAddressReg[c] <= DSTC_ADDR_RST;
        pendingReg[c] <= 1'b0;
      end
      else if (cfgLoad[c])
      begin
        channelModeReg[c] <= cfgData[c].mode;
        transferCountReg[c] <= cfgData[c].count;
        sourceAddressReg[c] <= cfgData[c].src;
        destinationAddressReg[c] <= cfgData[c].dst;
        pendingReg[c] <= 1'b0;
      end
      else
      begin
        // A new trigger wins over the clear made when the channel is granted.
        pendingReg[c] <= trigAccept[c] || (pendingReg[c] && !(startRead && grantCh == DSTC_CH_W'(c)));
        if (isDone)
        begin
          transferCountReg[c] <= transferCountReg[c] - 24'h000001;
          if (channelModeReg[c].srcInc)
            sourceAddressReg[c] <= sourceAddressReg[c] + unitStep(bufOut.size);
          if (channelModeReg[c].dstInc)
            destinationAddressReg[c] <= destinationAddressReg[c] + unitStep(bufOut.size);
        end
      end
    end

    assign transferCounter[c] = transferCountReg[c];
    assign sourceAddress[c] = sourceAddressReg[c];
    assign destinationAddress[c] = destinationAddressReg[c];
  end

  // Engine: one stolen read cycle, then one stolen write cycle, per unit.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stateReg <= DSTC_ST_IDLE;
      activeChReg <= '0;
      busReqReg <= 1'b0;
      busWriteReg <= 1'b0;
      busAddrReg <= DSTC_ADDR_RST;
      busWdataReg <= '0;
      busSizeReg <= DSTC_SZ_BYTE;
      xferDoneReg <= 1'b0;
      xferDoneChReg <= '0;
    end
    else
    begin
      xferDoneReg <= writeDone;
      xferDoneChReg <= writeDone ? bufOut.ch : xferDoneChReg;
      case (stateReg)
        DSTC_ST_IDLE:
        begin
          if (startRead)
          begin
            stateReg <= DSTC_ST_READ;
            activeChReg <= grantCh;
            busReqReg <= 1'b1;
            busWriteReg <= 1'b0;
            busAddrReg <= sourceAddressReg[grantCh];
            busSizeReg <= channelModeReg[grantCh].size;
          end
        end
        DSTC_ST_READ:
        begin
          if (readDone)
          begin
            stateReg <= DSTC_ST_WRITE;
            busReqReg <= 1'b0;
          end
        end
        DSTC_ST_WRITE:
        begin
          if (startWrite)
          begin
            busReqReg <= 1'b1;
            busWriteReg <= 1'b1;
            busAddrReg <= bufOut.addr;
            busWdataReg <= bufOut.data;
            busSizeReg <= bufOut.size;
          end
          else if (writeDone)
          begin
            stateReg <= DSTC_ST_IDLE;
            busReqReg <= 1'b0;
            busWriteReg <= 1'b0;
          end
        end
        default:
        begin
          stateReg <= DSTC_ST_IDLE;
          busReqReg <= 1'b0;
        end
      endcase
    end
  end

  // Outputs straight from flip-flops.
  assign busReq = busReqReg;
  assign busWrite = busWriteReg;
  assign busAddr = busAddrReg;
  assign busWdata = busWdataReg;
  assign busSize = busSizeReg;
  assign chPending = pendingReg;
  assign xferDone = xferDoneReg;
  assign xferDoneCh = xferDoneChReg;

endmodule

// [dstc_pkg.sv]
// Shared types and constants for the single transfer DMA channel controller.
// Assumes one system clock and a simple request/acknowledge memory bus.
package dstc_pkg;

  // Channel count, widths and reset values.
  localparam int DSTC_NUM_CH = 4;
  localparam int DSTC_MAX_CH = 4;
  localparam int DSTC_CH_W = 2;
  localparam int DSTC_ADDR_W = 32;
  localparam int DSTC_DATA_W = 32;
  localparam int DSTC_CNT_W = 24;
  localparam int DSTC_BUF_DEPTH = 2;
  localparam logic [DSTC_CNT_W-1:0] DSTC_COUNT_ZERO = 24'h000000;
  localparam logic [DSTC_CNT_W-1:0] DSTC_COUNT_RST = 24'h000000;
  localparam logic [DSTC_ADDR_W-1:0] DSTC_ADDR_RST = 32'h00000000;
  localparam logic [DSTC_ADDR_W-1:0] DSTC_STEP_BYTE = 32'h00000001;
  localparam logic [DSTC_ADDR_W-1:0] DSTC_STEP_HALF = 32'h00000002;
  localparam logic [DSTC_ADDR_W-1:0] DSTC_STEP_WORD = 32'h00000004;

  // Transfer unit width of a channel.
  typedef enum logic [1:0] {
    DSTC_SZ_BYTE = 2'h0,
    DSTC_SZ_HALF = 2'h1,
    DSTC_SZ_WORD = 2'h2
  } dstc_size_t;

  // Trigger source of a channel.
  typedef enum logic {
    DSTC_TRIG_SOFT = 1'h0,
    DSTC_TRIG_EXT_FALL = 1'h1
  } dstc_trig_t;

  // Engine states, Gray coded along idle, read, write.
  typedef enum logic [1:0] {
    DSTC_ST_IDLE = 2'h0,
    DSTC_ST_READ = 2'h1,
    DSTC_ST_WRITE = 2'h3
  } dstc_state_t;

  // Content of the channel mode register.
  typedef struct packed {
    dstc_size_t size;
    logic srcInc;
    logic dstInc;
    dstc_trig_t trig;
  } dstc_mode_t;

  localparam dstc_mode_t DSTC_MODE_RST = '{DSTC_SZ_BYTE, 1'b0, 1'b0, DSTC_TRIG_SOFT};

  // One channel set-up, applied by a load pulse.
  typedef struct packed {
    dstc_mode_t mode;
    logic [DSTC_CNT_W-1:0] count;
    logic [DSTC_ADDR_W-1:0] src;
    logic [DSTC_ADDR_W-1:0] dst;
  } dstc_cfg_t;

  // One unit held between its read and its write.
  typedef struct packed {
    logic [DSTC_DATA_W-1:0] data;
    logic [DSTC_ADDR_W-1:0] addr;
    dstc_size_t size;
    logic [DSTC_CH_W-1:0] ch;
  } dstc_beat_t;

endpackage

// [dstc_properties.sv]
// Concurrent checks of the DMA channel controller at its top ports.
// Assumes one clock and one unit in flight on the memory bus.
`timescale 1ns/1ps
module dstc_properties
  import dstc_pkg::*;
#(parameter int NUM_CH = DSTC_NUM_CH)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Set-up
  input wire logic [NUM_CH-1:0] cfgLoad,
  input wire dstc_cfg_t [NUM_CH-1:0] cfgData,
  // Memory bus
  input wire logic busReq,
  input wire logic busWrite,
  input wire logic [DSTC_ADDR_W-1:0] busAddr,
  input wire logic [DSTC_DATA_W-1:0] busWdata,
  input wire dstc_size_t busSize,
  input wire logic busAck,
  input wire logic [DSTC_DATA_W-1:0] busRdata,
  // Status
  input wire logic [NUM_CH-1:0][DSTC_CNT_W-1:0] transferCounter,
  input wire logic [NUM_CH-1:0][DSTC_ADDR_W-1:0] sourceAddress,
  input wire logic [NUM_CH-1:0][DSTC_ADDR_W-1:0] destinationAddress,
  input wire logic [NUM_CH-1:0] chPending,
  input wire logic xferDone,
  input wire logic [DSTC_CH_W-1:0] xferDoneCh
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [DSTC_DATA_W-1:0] rdHeld;
  dstc_mode_t modeReg;
  logic [DSTC_ADDR_W-1:0] stepW;
  // The ports do not show a mode after its load, so channel 0 keeps a copy.
  assign stepW = (modeReg.size == DSTC_SZ_HALF) ? DSTC_STEP_HALF :
    (modeReg.size == DSTC_SZ_WORD) ? DSTC_STEP_WORD : DSTC_STEP_BYTE;
  // Read data and mode are captured at the edges where they are taken.
  always_ff @(posedge clk)
  begin
    if (busReq && !busWrite && busAck) rdHeld <= busRdata;
    if (rst) modeReg <= DSTC_MODE_RST;
    else if (cfgLoad[0]) modeReg <= cfgData[0].mode;
  end
  sequence s_rdAck; busReq && !busWrite && busAck; endsequence
  sequence s_wrAck; busReq && busWrite && busAck; endsequence
  sequence s_done0; xferDone && xferDoneCh == 2'h0; endsequence
  property p_reqHold;
    busReq && !busAck |=> busReq && $stable(busAddr) && $stable(busWrite) && $stable(busSize);
  endproperty
  property p_readThenWrite; s_rdAck |=> !busReq ##1 busReq && busWrite; endproperty
  property p_wdata; busReq && busWrite |-> busWdata == rdHeld; endproperty
  property p_doneAfterWrite; s_wrAck |=> xferDone && !busReq; endproperty
  property p_doneCause; xferDone |-> $past(busReq && busWrite && busAck); endproperty
  property p_countStep;
    s_done0 |-> transferCounter[0] == $past(transferCounter[0]) - 24'h000001;
  endproperty
  property p_srcStep;
    s_done0 |-> sourceAddress[0] == $past(sourceAddress[0]) + (modeReg.srcInc ? stepW : '0);
  endproperty
  property p_dstStep; s_done0 |->
    destinationAddress[0] == $past(destinationAddress[0]) + (modeReg.dstInc ? stepW : '0);
  endproperty
  property p_zeroIgnore;
    transferCounter[0] == DSTC_COUNT_ZERO && !chPending[0] |=> !chPending[0];
  endproperty
  property p_grant; $fell(chPending[0]) && !$past(cfgLoad[0]) |->
    busReq && !busWrite && busAddr == sourceAddress[0];
  endproperty
  a_reqHold: assert property (p_reqHold) else $error("request changed before ack");
  a_readThenWrite: assert property (p_readThenWrite) else $error("no write after read");
  a_wdata: assert property (p_wdata) else $error("write data differs from read");
  a_doneAfterWrite: assert property (p_doneAfterWrite) else $error("no done");
  a_doneCause: assert property (p_doneCause) else $error("done without write");
  a_countStep: assert property (p_countStep) else $error("count step wrong");
  a_srcStep: assert property (p_srcStep) else $error("source step wrong");
  a_dstStep: assert property (p_dstStep) else $error("destination step wrong");
  a_zeroIgnore: assert property (p_zeroIgnore) else $error("zero count accepted");
  a_grant: assert property (p_grant) else $error("grant without source read");
endmodule

bind dstc_channel_ctrl dstc_properties #(.NUM_CH(NUM_CH)) chk_u (.clk, .rst, .cfgLoad,
  .cfgData, .busReq, .busWrite, .busAddr, .busWdata, .busSize, .busAck, .busRdata,
  .transferCounter,
  .sourceAddress, .destinationAddress, .chPending, .xferDone, .xferDoneCh);

// [dstc_mem_model.sv]
// Memory bus model answering the channel's requests after wait states.
// Assumes one request at a time, held until its acknowledge.
`timescale 1ns/1ps
module dstc_mem_model
  import dstc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Requests
  input wire logic busReq,
  input wire logic busWrite,
  input wire logic [DSTC_ADDR_W-1:0] busAddr,
  input wire logic [DSTC_DATA_W-1:0] busWdata,
  input wire dstc_size_t busSize,
  input wire logic [3:0] waitCycles,
  // Answers and write record
  output logic busAck,
  output logic [DSTC_DATA_W-1:0] busRdata,
  output logic [DSTC_ADDR_W-1:0] lastWaddr,
  output logic [DSTC_DATA_W-1:0] lastWdata,
  output dstc_size_t lastWsize,
  output logic [7:0] nWrites
);
  logic [3:0] waitReg;
  logic ackNow;
  // The ack is due once the wait states run out.
  assign ackNow = busReq && !busAck && waitReg == waitCycles;
  // Read data toggles outside the ack so a stale sample never matches.
  always_ff @(posedge clk)
  begin
    busRdata <= rst ? '0 : ackNow ? busAddr ^ 32'hA5A5A5A5 : ~busRdata;
    busAck <= !rst && ackNow;
    waitReg <= (rst || ackNow || busAck || !busReq) ? 4'h0 : waitReg + 4'h1;
    if (rst) nWrites <= 8'h00;
    else if (ackNow && busWrite) nWrites <= nWrites + 8'h01;
    if (ackNow && busWrite) lastWaddr <= busAddr;
    if (ackNow && busWrite) lastWdata <= busWdata;
    if (ackNow && busWrite) lastWsize <= busSize;
  end
endmodule

// [dstc_channel_ctrl_test.sv]
// Self-checking bench for the DMA channel controller and a memory model.
// Assumes inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
module dstc_channel_ctrl_test
  import dstc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] cfgLoad = '0;
  logic [3:0] swTrig = '0;
  logic [3:0] extPin = 4'hF;
  logic [3:0] waitCycles = 4'h0;
  dstc_cfg_t [3:0] cfgData = '0;
  logic busReq, busWrite, busAck, xferDone;
  logic [31:0] busAddr, busWdata, busRdata, lastWaddr, lastWdata;
  logic [3:0][23:0] transferCounter;
  logic [3:0][31:0] sourceAddress, destinationAddress;
  logic [3:0] chPending;
  logic [1:0] xferDoneCh;
  logic [7:0] nWrites;
  dstc_size_t busSize, lastWsize;
  int miscompares = 0;
  int nCompared = 0;
  dstc_channel_ctrl dut_u (.clk, .rst, .cfgLoad, .cfgData, .swTrig,
    .externalTriggerInput(extPin), .busReq, .busWrite, .busAddr, .busWdata, .busSize,
    .busAck, .busRdata, .transferCounter, .sourceAddress, .destinationAddress, .chPending,
    .xferDone, .xferDoneCh);
  dstc_mem_model mem_u (.clk, .rst, .busReq, .busWrite, .busAddr, .busWdata, .busSize,
    .waitCycles, .busAck, .busRdata, .lastWaddr, .lastWdata, .lastWsize, .nWrites);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic load(input int c, input dstc_cfg_t cfg);
    cfgData[c] = cfg;
    cfgLoad[c] = 1'b1;
    tick(1);
    cfgLoad[c] = 1'b0;
  endtask
  // A missing done ends the run, since later checks would only cascade.
  task automatic waitDone(input bit want);
    bit seen = 1'b0;
    for (int k = 0; k < 60 && !seen; k++)
    begin
      tick(1);
      seen = (xferDone === 1'b1);
    end
    check(seen, want);
    if (want && !seen) complete_run();
  endtask
  // Pin falls on channel 0: five units move, the sixth trigger is dropped.
  task automatic sc_ext_byte;
    load(0, '{'{DSTC_SZ_BYTE, 1'b1, 1'b0, DSTC_TRIG_EXT_FALL}, 24'h000005, 32'h00000400,
      32'h00001000});
    for (int i = 0; i < 6; i++)
    begin
      extPin[0] = 1'b0;
      waitDone(i < 5);
      extPin[0] = 1'b1;
      tick(4);
      check(transferCounter[0], i < 5 ? 4 - i : 0);
      check(sourceAddress[0], 32'h00000401 + (i < 5 ? i : 4));
      check(destinationAddress[0], 32'h00001000);
      check(lastWaddr, 32'h00001000);
      check(lastWdata, (32'h00000400 + (i < 5 ? i : 4)) ^ 32'hA5A5A5A5);
      check(lastWsize, DSTC_SZ_BYTE);
    end
  endtask
  // Three sizes on soft triggers at once, with a slow bus and ignored pin falls.
  task automatic sc_soft_sizes;
    for (int c = 1; c < 4; c++)
      load(c, '{'{dstc_size_t'(c - 1), 1'b1, 1'b1, DSTC_TRIG_SOFT}, 24'h000003,
        32'h00002000, 32'h00003000});
    waitCycles = 4'h3;
    extPin = 4'h1;
    waitDone(1'b0);
    extPin = 4'hF;
    swTrig = 4'hE;
    tick(1);
    swTrig = 4'h0;
    for (int c = 1; c < 4; c++)
    begin
      waitDone(1'b1);
      check(xferDoneCh, c);
      check(lastWsize, c - 1);
      check(transferCounter[c], 24'h000002);
      check(sourceAddress[c], 32'h00002000 + (1 << (c - 1)));
      check(destinationAddress[c], 32'h00003000 + (1 << (c - 1)));
    end
    check(nWrites, 8);
  endtask
  // Free-running 100 MHz clock.
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Reset for six cycles, then the scenarios.
  initial
  begin
    tick(6);
    rst = 1'b0;
    sc_ext_byte();
    sc_soft_sizes();
    complete_run();
  end
endmodule
